// file: shared/accel_mode_pkg.sv
// Constants, register layout and state codes of the operating-mode controller.
// Assumes a 250 MHz core clock and a one-cycle register port beside it.
//
// Behaviour
// - Standby, measure, impact watch and wake-up modes
// - Measurement streams samples, every feature usable
// - Impact over threshold switches to measurement
// - Impact threshold low by default, option raises
// - Impact watch holds output data still
// - Wake cycles off for timer, on settle
// - Wake motion acts per configured responses
// - Wake keeps registers, refreshes data slowly
// - Wake never pushes FIFO, raises only the motion interrupt
// - Standby clears and blocks every interrupt
// - Power-up lands in standby, sensing off
// - Second interrupt pin doubles as sync input
// - First interrupt pin doubles as clock input
// - Register port sits behind serial slave
// - Settle time selectable, 370 or 16 ms
package accel_mode_pkg;

  // ----------------------------------------------------------------------
  // Register port and offsets
  // ----------------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam int         DATA_W       = 32;
  localparam int         SAMPLE_W     = 12;
  localparam logic [7:0] OFF_POWER    = 8'h00;
  localparam logic [7:0] OFF_CONFIG   = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_MASK     = 8'h0C;
  localparam logic [7:0] OFF_DATA     = 8'h10;
  localparam logic [7:0] OFF_STATE    = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PWR_MODE_LSB   = 0;   // Two bits of mode
  localparam int PWR_SETTLE     = 2;   // One selects the short settle
  localparam int PWR_IMPACT_HI  = 3;   // One selects the high threshold
  localparam int PWR_ACT_MEAS   = 4;   // Wake motion goes to measurement
  localparam int PWR_ACT_IRQ    = 5;   // Wake motion raises interrupt
  localparam int PWR_ACT_WAKE   = 6;   // Wake motion drives wake output
  localparam int PWR_W          = 7;
  localparam int CFG_TIMER_LSB  = 0;   // Three bits of wake timer select
  localparam int CFG_EXT_CLK    = 3;
  localparam int CFG_EXT_SYNC   = 4;
  localparam int CFG_W          = 5;
  localparam int ST_DATA        = 0;
  localparam int ST_IMPACT      = 1;
  localparam int ST_MOTION      = 2;
  localparam int ST_W           = 3;

  // ----------------------------------------------------------------------
  // Reset values and mode codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_MEASURE = 2'h1;
  localparam logic [1:0] MODE_IMPACT  = 2'h2;
  localparam logic [1:0] MODE_WAKE    = 2'h3;
  localparam logic [PWR_W-1:0] POWER_RST  = 7'h00;
  localparam logic [CFG_W-1:0] CONFIG_RST = 5'h00;
  localparam logic [ST_W-1:0]  MASK_RST   = 3'h0;

  // ----------------------------------------------------------------------
  // Clock, millisecond and phase-length constants
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 4;
  localparam int MS_NS             = 1000000;
  localparam int MS_CYCLES_DEFAULT = MS_NS / CLK_PERIOD_NS;
  localparam int DIV_W             = 18;
  localparam int MS_W              = 15;
  localparam logic [MS_W-1:0] SETTLE_LONG_MS  = 15'd370;
  localparam logic [MS_W-1:0] SETTLE_SHORT_MS = 15'd16;
  localparam logic [MS_W-1:0] WAKE_MS_0 = 15'd52;
  localparam logic [MS_W-1:0] WAKE_MS_1 = 15'd104;
  localparam logic [MS_W-1:0] WAKE_MS_2 = 15'd208;
  localparam logic [MS_W-1:0] WAKE_MS_3 = 15'd512;
  localparam logic [MS_W-1:0] WAKE_MS_4 = 15'd2048;
  localparam logic [MS_W-1:0] WAKE_MS_5 = 15'd4096;
  localparam logic [MS_W-1:0] WAKE_MS_6 = 15'd8192;
  localparam logic [MS_W-1:0] WAKE_MS_7 = 15'd24576;

  // ----------------------------------------------------------------------
  // Asynchronous inputs and states
  // ----------------------------------------------------------------------
  localparam int AIN_LOW   = 0;
  localparam int AIN_HIGH  = 1;
  localparam int AIN_MOT   = 2;
  localparam int AIN_CLK   = 3;
  localparam int AIN_SYNC  = 4;
  localparam int AIN_N     = 5;

  typedef enum logic [5:0] {
    S_STANDBY  = 6'b000001,
    S_SETTLE   = 6'b000010,
    S_MEASURE  = 6'b000100,
    S_IMPACT   = 6'b001000,
    S_WAKE_OFF = 6'b010000,
    S_WAKE_ON  = 6'b100000
  } state_type;

endpackage

// file: hw/pin_sync_edge.sv
// Two-stage synchroniser with rising-edge detect for one pin.
// Assumes the pin is asynchronous to clock and slower than half its rate.
`timescale 1ns/1ps
module pin_sync_edge (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ----------------------------------------------------------------------
  // Synchroniser; only sync_r reads meta_r
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edge seen from the clean stages only
  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;

endmodule

// file: hw/accel_mode_ctrl.sv
// Operating-mode sequencer with register port, interrupts and pin muxing.
// Assumes a serial slave in front turns host frames into one-cycle strobes
// and that the front end delivers samples on this clock.
`timescale 1ns/1ps
module accel_mode_ctrl
  import accel_mode_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [DATA_W-1:0]   rdata,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  input  wire logic                impact_low_hit,
  input  wire logic                impact_high_hit,
  input  wire logic                motion_hit,
  input  wire logic                irq_out_a_ext_clk_in,
  output logic                     irq_out_a_ext_clk_in_drv,
  output logic                     irq_out_a_ext_clk_in_oe,
  input  wire logic                irq_out_b_sync_in,
  output logic                     irq_out_b_sync_in_drv,
  output logic                     irq_out_b_sync_in_oe,
  output logic                     irq,
  output logic                     fifo_push,
  output logic      [SAMPLE_W-1:0] fifo_data,
  output logic                     wake_out,
  output logic                     sense_on
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic state_type entry_state(input logic [1:0] m);
    unique case (m)
      MODE_MEASURE: entry_state = S_SETTLE;
      MODE_IMPACT:  entry_state = S_IMPACT;
      MODE_WAKE:    entry_state = S_WAKE_OFF;
      default:      entry_state = S_STANDBY;
    endcase
  endfunction

  function automatic logic [MS_W-1:0] wake_ms(input logic [2:0] sel);
    unique case (sel)
      3'h0:    wake_ms = WAKE_MS_0;
      3'h1:    wake_ms = WAKE_MS_1;
      3'h2:    wake_ms = WAKE_MS_2;
      3'h3:    wake_ms = WAKE_MS_3;
      3'h4:    wake_ms = WAKE_MS_4;
      3'h5:    wake_ms = WAKE_MS_5;
      3'h6:    wake_ms = WAKE_MS_6;
      default: wake_ms = WAKE_MS_7;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [AIN_N-1:0]    ain;
  logic [AIN_N-1:0]    ain_lvl;
  logic [AIN_N-1:0]    ain_rise;
  state_type           state_r, state_nxt;
  logic [PWR_W-1:0]    power_config_reg_r, power_nxt;
  logic [CFG_W-1:0]    config_reg_a_r, config_nxt;
  logic [ST_W-1:0]     stat_r, stat_nxt, stat_set;
  logic [ST_W-1:0]     mask_r, mask_nxt;
  logic [DIV_W-1:0]    div_r, div_nxt;
  logic [MS_W-1:0]     ms_cnt_r, ms_nxt;
  logic [SAMPLE_W-1:0] data_r, data_nxt;
  logic [DATA_W-1:0]   rdata_r, rdata_nxt;
  logic                push_r, push_nxt;
  logic                wake_r, wake_nxt;
  logic                irq_r, irq_nxt;
  logic                drv_a_r, oe_a_r, drv_b_r, oe_b_r;
  logic                sense_r;
  logic [1:0]          mode;
  logic [2:0]          wake_timer_select;
  logic                ext_clk_en, ext_sync_en, ms_tick, impact_rise;
  logic                sample_take, sample_go, data_ok;
  logic [MS_W-1:0]     settle_ms, period_ms;
  logic                wr_power, wr_config, wr_status, wr_mask;

  assign mode              = power_config_reg_r[PWR_MODE_LSB +: 2];
  assign wake_timer_select = config_reg_a_r[CFG_TIMER_LSB +: 3];
  assign ext_clk_en        = config_reg_a_r[CFG_EXT_CLK];
  assign ext_sync_en       = config_reg_a_r[CFG_EXT_SYNC];
  // Short settle when PWR_SETTLE is set, long one otherwise
  assign settle_ms = power_config_reg_r[PWR_SETTLE] ? SETTLE_SHORT_MS
                                                    : SETTLE_LONG_MS;
  assign period_ms = wake_ms(wake_timer_select);

  // Strobe decode; the serial slave in front only ever emits these
  assign wr_power  = wr_en && (addr == OFF_POWER);
  assign wr_config = wr_en && (addr == OFF_CONFIG);
  assign wr_status = wr_en && (addr == OFF_STATUS);
  assign wr_mask   = wr_en && (addr == OFF_MASK);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  assign ain = {irq_out_b_sync_in, irq_out_a_ext_clk_in, motion_hit,
                impact_high_hit, impact_low_hit};

  // Every asynchronous level gets the same two-stage treatment
  for (genvar i = 0; i < AIN_N; i++) begin : g_sync
    pin_sync_edge u_sync (
      .clock (clock),
      .rst   (rst),
      .pin   (ain[i]),
      .level (ain_lvl[i]),
      .rise  (ain_rise[i])
    );
  end

  // Threshold pick between the two impact comparators
  assign impact_rise = power_config_reg_r[PWR_IMPACT_HI] ? ain_rise[AIN_HIGH]
                                                         : ain_rise[AIN_LOW];

  // ----------------------------------------------------------------------
  // Millisecond divider and phase counter
  // ----------------------------------------------------------------------
  // Both restart on a state change so each phase lasts whole milliseconds
  assign ms_tick = (div_r == DIV_W'(MS_CYCLES - 1));

  always_comb begin
    div_nxt = ms_tick ? '0 : div_r + 1'b1;
    ms_nxt  = ms_tick ? ms_cnt_r + 1'b1 : ms_cnt_r;
    if (state_nxt != state_r) begin
      div_nxt = '0;
      ms_nxt  = '0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_r    <= '0;
      ms_cnt_r <= '0;
    end else begin
      div_r    <= div_nxt;
      ms_cnt_r <= ms_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Mode sequencer and control registers
  // ----------------------------------------------------------------------
  // Hardware promotion to measurement wins over a host write in the same
  // cycle, so the event is never lost to a racing write.
  always_comb begin
    state_nxt  = state_r;
    power_nxt  = wr_power ? wdata[PWR_W-1:0] : power_config_reg_r;
    config_nxt = wr_config ? wdata[CFG_W-1:0] : config_reg_a_r;
    wake_nxt   = wake_r;
    unique case (state_r)
      S_STANDBY: begin
        state_nxt = entry_state(mode);
      end
      S_SETTLE: begin
        if (mode != MODE_MEASURE)
          state_nxt = entry_state(mode);
        else if (ms_tick && ms_cnt_r == settle_ms - 1'b1)
          state_nxt = S_MEASURE;
      end
      S_MEASURE: begin
        if (mode != MODE_MEASURE)
          state_nxt = entry_state(mode);
      end
      S_IMPACT: begin
        if (mode != MODE_IMPACT) begin
          state_nxt = entry_state(mode);
        end else if (impact_rise) begin
          state_nxt = S_MEASURE;
          power_nxt[PWR_MODE_LSB +: 2] = MODE_MEASURE;
        end
      end
      S_WAKE_OFF: begin
        if (mode != MODE_WAKE)
          state_nxt = entry_state(mode);
        else if (ms_tick && ms_cnt_r == period_ms - 1'b1)
          state_nxt = S_WAKE_ON;
      end
      S_WAKE_ON: begin
        if (mode != MODE_WAKE) begin
          state_nxt = entry_state(mode);
        end else if (ain_rise[AIN_MOT]) begin
          if (power_config_reg_r[PWR_ACT_WAKE])
            wake_nxt = 1'b1;
          if (power_config_reg_r[PWR_ACT_MEAS]) begin
            state_nxt = S_MEASURE;
            power_nxt[PWR_MODE_LSB +: 2] = MODE_MEASURE;
          end
        end else if (ms_tick && ms_cnt_r == settle_ms - 1'b1) begin
          state_nxt = S_WAKE_OFF;
        end
      end
      default: state_nxt = S_STANDBY;
    endcase
    // Downstream wake request drops only when the host parks the device
    if (state_nxt == S_STANDBY)
      wake_nxt = 1'b0;
  end

  // Power-up: standby, mode field at standby, sensing off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r            <= S_STANDBY;
      power_config_reg_r <= POWER_RST;
      config_reg_a_r     <= CONFIG_RST;
      wake_r             <= 1'b0;
    end else begin
      state_r            <= state_nxt;
      power_config_reg_r <= power_nxt;
      config_reg_a_r     <= config_nxt;
      wake_r             <= wake_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Sampling, data register and FIFO feed
  // ----------------------------------------------------------------------
  // External clock replaces the internal strobe; sync gates it further
  assign sample_take = ext_clk_en ? ain_rise[AIN_CLK] : sample_valid;
  assign sample_go   = ext_sync_en ? (sample_take & ain_lvl[AIN_SYNC])
                                   : sample_take;
  // A sample lands whole and only when the state is not moving this cycle
  assign data_ok = (state_r == S_MEASURE || state_r == S_WAKE_ON) &&
                   (state_nxt == state_r);

  always_comb begin
    data_nxt = data_r;
    push_nxt = 1'b0;
    if (sample_go && data_ok) begin
      data_nxt = sample_data;
      push_nxt = (state_r == S_MEASURE);
    end
  end

  // Impact watch leaves data_r untouched as data_ok is low there
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_r <= '0;
      push_r <= 1'b0;
    end else begin
      data_r <= data_nxt;
      push_r <= push_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, mask and pins
  // ----------------------------------------------------------------------
  // Wake mode raises only the motion bit, and only if asked to
  always_comb begin
    stat_set = '0;
    stat_set[ST_DATA]   = push_nxt;
    stat_set[ST_IMPACT] = (state_r == S_IMPACT) && impact_rise &&
                          (mode == MODE_IMPACT);
    stat_set[ST_MOTION] = (state_r == S_WAKE_ON) && ain_rise[AIN_MOT] &&
                          power_config_reg_r[PWR_ACT_IRQ];
    stat_nxt = stat_r;
    if (wr_status)
      stat_nxt = stat_r & ~wdata[ST_W-1:0];
    stat_nxt = stat_nxt | stat_set;                             // Set wins
    if (state_nxt == S_STANDBY)
      stat_nxt = '0;
    mask_nxt = wr_mask ? wdata[ST_W-1:0] : mask_r;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  // Pins turn around to inputs when used for external clock or sync
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_r  <= '0;
      mask_r  <= MASK_RST;
      irq_r   <= 1'b0;
      drv_a_r <= 1'b0;
      oe_a_r  <= 1'b0;
      drv_b_r <= 1'b0;
      oe_b_r  <= 1'b0;
      sense_r <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      irq_r   <= irq_nxt;
      drv_a_r <= irq_nxt & ~config_nxt[CFG_EXT_CLK];
      oe_a_r  <= ~config_nxt[CFG_EXT_CLK];
      drv_b_r <= irq_nxt & ~config_nxt[CFG_EXT_SYNC];
      oe_b_r  <= ~config_nxt[CFG_EXT_SYNC];
      sense_r <= (state_nxt != S_STANDBY) && (state_nxt != S_WAKE_OFF);
    end
  end

  // ----------------------------------------------------------------------
  // Read path: data one cycle after the strobe, zero when unmapped
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    if (rd_en) begin
      unique case (addr)
        OFF_POWER:  rdata_nxt[PWR_W-1:0]    = power_config_reg_r;
        OFF_CONFIG: rdata_nxt[CFG_W-1:0]    = config_reg_a_r;
        OFF_STATUS: rdata_nxt[ST_W-1:0]     = stat_r;
        OFF_MASK:   rdata_nxt[ST_W-1:0]     = mask_r;
        OFF_DATA:   rdata_nxt[SAMPLE_W-1:0] = data_r;
        OFF_STATE:  rdata_nxt[5:0]          = state_r;
        default:    rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      rdata_r <= '0;
    else
      rdata_r <= rdata_nxt;
  end

  // Outputs straight from flops
  assign rdata                    = rdata_r;
  assign irq                      = irq_r;
  assign fifo_push                = push_r;
  assign fifo_data                = data_r;
  assign wake_out                 = wake_r;
  assign sense_on                 = sense_r;
  assign irq_out_a_ext_clk_in_drv = drv_a_r;
  assign irq_out_a_ext_clk_in_oe  = oe_a_r;
  assign irq_out_b_sync_in_drv    = drv_b_r;
  assign irq_out_b_sync_in_oe     = oe_b_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence off_done_s;
    state_r == S_WAKE_OFF && mode == MODE_WAKE && ms_tick &&
    ms_cnt_r == period_ms - 1'b1;
  endsequence

  sequence on_phase_s;
    state_r == S_WAKE_ON ##1 state_r == S_WAKE_ON;
  endsequence

  standby_clear_a: assert property (
    state_r == S_STANDBY |-> stat_r == '0 && !irq_r)
    else $error("status not clear in standby");

  impact_switch_a: assert property (
    state_r == S_IMPACT && mode == MODE_IMPACT && impact_rise |=>
    state_r == S_MEASURE && mode == MODE_MEASURE)
    else $error("impact did not promote to measurement");

  impact_hold_a: assert property (
    state_r == S_IMPACT |=> $stable(data_r))
    else $error("data changed during impact watch");

  wake_fifo_a: assert property (
    state_r == S_WAKE_ON || state_r == S_WAKE_OFF |=>
    !push_r && !$rose(stat_r[ST_DATA]))
    else $error("wake mode fed fifo or data interrupt");

  stay_standby_a: assert property (
    state_r == S_STANDBY && mode == MODE_STANDBY && !wr_power |=>
    state_r == S_STANDBY && !sense_r)
    else $error("left standby without a mode write");

  settle_done_a: assert property (
    state_r == S_SETTLE && mode == MODE_MEASURE && ms_tick &&
    ms_cnt_r == settle_ms - 1'b1 |=> state_r == S_MEASURE)
    else $error("settle phase length wrong");

  wake_period_a: assert property (
    off_done_s |=> on_phase_s or (state_r == S_WAKE_ON ##1 1'b1))
    else $error("wake timer did not open an on phase");

  wake_early_a: assert property (
    state_r == S_WAKE_OFF && mode == MODE_WAKE &&
    ms_cnt_r < period_ms - 1'b1 |=> state_r != S_WAKE_ON)
    else $error("wake on phase started early");

  data_whole_a: assert property (
    $changed(data_r) |-> $past(state_r) == state_r)
    else $error("sample landed across a mode change");

  pin_turn_a: assert property (
    ext_clk_en && $stable(ext_clk_en) |-> !oe_a_r && !drv_a_r)
    else $error("clock pin driven while used as input");

  read_data_a: assert property (
    rd_en && addr == OFF_DATA |=> rdata_r[SAMPLE_W-1:0] == $past(data_r))
    else $error("data read returned wrong value");

endmodule

// file: bench/ext_clk_src.sv
// Far-side sample clock source for the shared pin A.
// Assumes the bench raises run only while pin A is an input.
`timescale 1ns/1ps
module ext_clk_src (
  input  wire logic run,
  output logic      clk_out
);
  // Stands low between bursts, 48 ns period inside
  initial begin
    clk_out = 1'b0;
    #1;
    forever begin
      #24;
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule

// file: bench/testbench.sv
// Register-level bench of the mode controller.
// Assumes MS_CYCLES of 4, so one millisecond is four clocks.
`timescale 1ns/1ps
module testbench;
  import accel_mode_pkg::*;
  logic clock = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic sample_valid = 1'b0, impact_low_hit = 1'b0, motion_hit = 1'b0;
  logic impact_high_hit = 1'b0, sync_lvl = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v, v2;
  logic [11:0] sample_data = 12'h000, fifo_data;
  logic run = 1'b0, pa, pb, a_drv, a_oe, b_drv, b_oe, ext;
  logic irq, fifo_push, wake_out, sense_on;
  int   num_errors = 0, n_tests = 0;
  // Pin levels resolved from the enables; a released pin B shows the far
  // side's sync level, high at rest like a pull-up
  assign pa = a_oe ? a_drv : ext;
  assign pb = b_oe ? b_drv : sync_lvl;
  always #2 clock = ~clock;
  ext_clk_src src (.run(run), .clk_out(ext));
  accel_mode_ctrl #(.MS_CYCLES(4)) DUT (.clock, .rst, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .sample_valid, .sample_data,
    .impact_low_hit, .impact_high_hit, .motion_hit,
    .irq_out_a_ext_clk_in(pa), .irq_out_a_ext_clk_in_drv(a_drv),
    .irq_out_a_ext_clk_in_oe(a_oe), .irq_out_b_sync_in(pb),
    .irq_out_b_sync_in_drv(b_drv), .irq_out_b_sync_in_oe(b_oe),
    .irq, .fifo_push, .fifo_data, .wake_out, .sense_on);
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Bus cycles: one-cycle strobes launched right after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  task automatic smp(input logic [11:0] d);
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_data <= d;
    @(posedge clock);
    sample_valid <= 1'b0;
  endtask
  // Bounded polls; a bound used up ends the run
  task automatic wst(input logic [31:0] e);
    v = 32'h0;
    for (int i = 0; i < 400 && v !== e; i++) rd(OFF_STATE, v);
    chk(v, e);
    if (v !== e) end_of_test();
  endtask
  task automatic wt(ref logic s);
    for (int i = 0; i < 3000 && s !== 1'b1; i++) @(negedge clock);
    chk(s, 1);
    if (s !== 1'b1) end_of_test();
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(OFF_STATE, v);
    chk(v, 32'h1);
    chk({sense_on, a_oe}, 2'b01);
    rd(8'h20, v);
    chk(v, 32'h0);
    wr(OFF_MASK, 32'h7);
    wr(OFF_POWER, 32'h5);
    wst(32'h2);
    wst(32'h4);
    smp(12'hABC);
    @(negedge clock);
    chk({fifo_push, fifo_data, irq}, {1'b1, 12'hABC, 1'b1});
    wr(OFF_POWER, 32'h0);
    wst(32'h1);
    rd(OFF_STATUS, v);
    chk(v, 32'h0);
    chk(irq, 0);
    wr(OFF_POWER, 32'h2);
    wst(32'h8);
    rd(OFF_DATA, v2);
    smp(12'h123);
    rd(OFF_DATA, v);
    chk(v, v2);
    @(posedge clock);
    impact_low_hit <= 1'b1;
    wst(32'h4);
    @(posedge clock);
    impact_low_hit <= 1'b0;
    rd(OFF_POWER, v);
    chk(v, 32'h1);
    chk(irq, 1);
    wr(OFF_STATUS, 32'h2);
    @(negedge clock);
    chk(irq, 0);
    wr(OFF_POWER, 32'h0);
    wr(OFF_POWER, 32'h63);
    wst(32'h20);
    smp(12'h456);
    @(negedge clock);
    chk(fifo_push, 0);
    rd(OFF_DATA, v);
    chk(v, 32'h456);
    @(posedge clock);
    motion_hit <= 1'b1;
    wt(wake_out);
    chk(irq, 1);
    @(posedge clock);
    motion_hit <= 1'b0;
    wr(OFF_POWER, 32'h0);
    // Standby lands one edge after the mode field, so look a cycle later
    repeat (2) @(negedge clock);
    chk({wake_out, irq, sense_on}, 3'b000);
    wr(OFF_CONFIG, 32'h8);
    @(negedge clock);
    chk(a_oe, 0);
    wr(OFF_POWER, 32'h5);
    wst(32'h4);
    @(posedge clock);
    sample_data <= 12'h5A5;
    run <= 1'b1;
    wt(fifo_push);
    run <= 1'b0;
    chk(fifo_data, 12'h5A5);
    // Pin A back to interrupt output, pin B turned into the sync input
    wr(OFF_CONFIG, 32'h10);
    @(negedge clock);
    chk({a_oe, a_drv, b_oe, b_drv, sense_on}, 5'h19);
    // Sync level low gates the sample strobe off
    @(posedge clock);
    sync_lvl <= 1'b0;
    repeat (4) @(posedge clock);
    smp(12'h111);
    @(negedge clock);
    chk({fifo_push, fifo_data}, {1'b0, 12'h5A5});
    @(posedge clock);
    sync_lvl <= 1'b1;
    repeat (4) @(posedge clock);
    smp(12'h222);
    @(negedge clock);
    chk({fifo_push, fifo_data}, {1'b1, 12'h222});
    // High threshold: the low comparator alone must not promote
    wr(OFF_POWER, 32'hA);
    wst(32'h8);
    @(posedge clock);
    impact_low_hit <= 1'b1;
    repeat (6) @(posedge clock);
    rd(OFF_STATE, v);
    chk(v, 32'h8);
    @(posedge clock);
    impact_low_hit <= 1'b0;
    impact_high_hit <= 1'b1;
    wst(32'h4);
    rd(OFF_POWER, v);
    chk(v, 32'h9);
    end_of_test();
  end
endmodule
